// ===== rtl/fbd_dma.sv

// ----------------------------------------
// two entry buffer
// ----------------------------------------
module fbd_buf2 import fbd_pkg::*; (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [BUF_W-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [BUF_W-1:0] out_data_o
);
	logic [BUF_W-1:0] mem [BUF_DEPTH];
	logic             wp;
	logic             rp;
	logic [1:0]       cnt;
	logic             push;
	logic             pop;

	// honest full and empty
	assign in_ready_o  = (cnt != 2'(BUF_DEPTH));
	assign out_valid_o = (cnt != 2'h0);
	assign out_data_o  = mem[rp];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp] <= in_data_i;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp  <= 1'b0;
			rp  <= 1'b0;
			cnt <= 2'h0;
		end else begin
			if (push) wp <= ~wp;
			if (pop) rp <= ~rp;
			cnt <= cnt + 2'(push) - 2'(pop);
		end
	end
endmodule

// ----------------------------------------
// controller end
// ----------------------------------------
module fbd_dma (
	input  wire logic                      MCLK_I,
	input  wire logic                      RST_I,
	input  wire logic [fbd_pkg::NUM_CH-1:0] CH_EN_I,
	input  wire logic                      CFG_WE_I,
	input  wire logic [fbd_pkg::CH_W-1:0]  CFG_CH_I,
	input  wire logic [31:0]               CFG_PTR_I,
	input  wire logic                      CFG_TX_I,
	output logic                           CFG_RDY_O,
	output logic                           RETIRE_O,
	output logic [fbd_pkg::CH_W-1:0]       RETIRE_CH_O,
	output logic                           DESC_IRQ_O,
	output logic                           BUSY_O,
	fbd_if.dma                             bus
);
	import fbd_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_CTX, ST_FETCH, ST_CHECK, ST_MOVE, ST_WB, ST_SAVE} fbd_state_t;

	fbd_state_t        state;
	logic [31:0]       ctx [CTX_DEPTH];
	logic [CH_W-1:0]   ch;
	logic [CH_W-1:0]   last_ch;
	logic [2:0]        idx;
	logic [1:0]        cfg_step;
	logic [CH_W-1:0]   cfg_ch;
	logic [31:0]       cfg_ptr;
	logic              cfg_tx;
	logic [31:0]       init_ptr;
	logic              tx;
	logic [31:0]       cur_ptr;
	logic [31:0]       d_src;
	logic [LEN_W-1:0]  d_len;
	logic [31:0]       d_flg;
	logic [31:0]       addr;
	logic [LEN_W-1:0]  rem;
	logic [LEN_W-1:0]  moved;
	logic              eop;
	logic              err;
	logic              ctx_we;
	logic [CTX_AW-1:0] ctx_addr;
	logic [31:0]       ctx_wd;
	logic [31:0]       ctx_rd;
	logic [4:0]        pick;
	logic [2:0]        nb;
	logic [3:0]        be_cur;
	logic              bi_valid;
	logic              bi_ready;
	logic [BUF_W-1:0]  bi_data;
	logic              bo_valid;
	logic              bo_ready;
	logic [BUF_W-1:0]  bo_data;
	logic              fin;
	logic [31:0]       new_flg;

	// round robin pick among enabled requesting channels
	function automatic logic [4:0] rr_pick(input logic [NUM_CH-1:0] req, input logic [CH_W-1:0] last);
		logic [4:0]      r;
		logic [CH_W-1:0] c;
		r = 5'h00;
		for (int i = NUM_CH; i >= 1; i--) begin
			c = last + CH_W'(i);
			if (req[c]) r = {1'b1, c};
		end
		return r;
	endfunction

	// bytes enabled in a lane mask
	function automatic logic [2:0] pop4(input logic [3:0] m);
		return 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
	endfunction

	// ----------------------------------------
	// context memory, single port
	// ----------------------------------------
	assign ctx_rd = ctx[ctx_addr];

	// port owner: configuration steps, else the machine
	always_comb begin
		ctx_we   = 1'b0;
		ctx_addr = {ch, idx};
		ctx_wd   = WORD_RST;
		if (cfg_step != 2'h0) begin
			ctx_we   = 1'b1;
			ctx_addr = {cfg_ch, 3'(cfg_step - 2'h1)};
			ctx_wd   = (cfg_step == 2'h2) ? {31'h0, cfg_tx} : cfg_ptr;
		end else if (state == ST_SAVE) begin
			ctx_we = 1'b1;
			unique case (idx)
				3'h0: begin ctx_addr = {ch, CTX_SRC}; ctx_wd = d_src; end
				3'h1: begin ctx_addr = {ch, CTX_LEN}; ctx_wd = {16'h0, d_len - moved}; end
				3'h2: begin ctx_addr = {ch, CTX_DST}; ctx_wd = WORD_RST; end
				3'h3: begin ctx_addr = {ch, CTX_FLG}; ctx_wd = new_flg; end
				default: begin
					ctx_addr = {ch, CTX_STAT};
					ctx_wd   = d_flg[FLG_WRAP] ? init_ptr : cur_ptr + DESC_STRIDE;
				end
			endcase
		end
	end

	// context write, 16 channels of 8 words
	always_ff @(posedge MCLK_I) begin
		if (ctx_we) begin
			ctx[ctx_addr] <= ctx_wd;
		end
	end

	// configuration writes pointer, control, current pointer
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			cfg_step <= 2'h0;
			cfg_ch   <= '0;
			cfg_ptr  <= WORD_RST;
			cfg_tx   <= 1'b0;
		end else if (cfg_step != 2'h0) begin
			cfg_step <= (cfg_step == 2'h3) ? 2'h0 : cfg_step + 2'h1;
		end else if (CFG_WE_I && CFG_RDY_O) begin
			cfg_step <= 2'h1;
			cfg_ch   <= CFG_CH_I;
			cfg_ptr  <= CFG_PTR_I;
			cfg_tx   <= CFG_TX_I;
		end
	end

	assign CFG_RDY_O = (state == ST_IDLE) && (cfg_step == 2'h0);
	assign pick      = rr_pick(CH_EN_I & bus.per_req, last_ch);

	// ----------------------------------------
	// data path through the buffer
	// ----------------------------------------
	// lanes from byte offset, clipped by bytes left
	always_comb begin
		nb = 3'h4 - 3'(addr[1:0]);
		if (rem < LEN_W'(nb)) nb = rem[2:0];
		be_cur = 4'(((5'h01 << nb) - 5'h01) << addr[1:0]);
	end

	assign bi_valid = tx ? (bus.mem_req && bus.mem_ack && state == ST_MOVE)
	                     : (bus.per_rx_valid && bus.per_rx_ready);
	assign bi_data  = tx ? {bus.mem_rdata, be_cur, (rem == LEN_W'(nb)) && d_flg[FLG_LAST]}
	                     : {bus.per_rx_data, bus.per_rx_be, bus.per_rx_eop};
	assign bo_ready = tx ? bus.per_tx_ready : (bus.mem_ack && bus.mem_we && state == ST_MOVE);

	fbd_buf2 u_buf (
		.clk_i       (MCLK_I),
		.rst_i       (RST_I),
		.in_valid_i  (bi_valid),
		.in_ready_o  (bi_ready),
		.in_data_i   (bi_data),
		.out_valid_o (bo_valid),
		.out_ready_i (bo_ready),
		.out_data_o  (bo_data)
	);

	// peripheral side handshakes
	assign bus.per_tx_valid = tx && state == ST_MOVE && bo_valid;
	assign bus.per_tx_data  = bo_data[36:5];
	assign bus.per_tx_be    = bo_data[4:1];
	assign bus.per_tx_last  = bo_data[0];
	assign bus.per_rx_ready = !tx && state == ST_MOVE && bi_ready && rem != '0 && !eop && !err;
	assign bus.per_ch       = ch;
	assign bus.per_act      = (state == ST_MOVE);
	assign BUSY_O           = (state != ST_IDLE);

	assign fin = (rem == '0 || eop || err) && !bo_valid && !bus.mem_req;

	// retired flags: full set on fill, cleared on empty
	always_comb begin
		new_flg           = {d_flg[31:16], bus.per_stat};
		new_flg[FLG_FULL] = !tx;
		if (!tx) new_flg[FLG_LAST] = eop;
	end

	// ----------------------------------------
	// shared channel machine
	// ----------------------------------------
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			state   <= ST_IDLE;
			idx     <= 3'h0;
			ch      <= '0;
			last_ch <= '0;
		end else begin
			unique case (state)
				ST_IDLE: if (pick[4] && cfg_step == 2'h0 && !CFG_WE_I) begin
					ch    <= pick[3:0];
					idx   <= 3'h0;
					state <= ST_CTX;
				end
				ST_CTX: begin
					idx <= (idx == 3'h2) ? 3'h0 : idx + 3'h1;
					if (idx == 3'h2) state <= ST_FETCH;
				end
				ST_FETCH: if (bus.mem_ack) begin
					idx <= (idx == 3'h3) ? 3'h0 : idx + 3'h1;
					if (idx == 3'h3) state <= ST_CHECK;
				end
				// never empty an empty buffer nor fill a full one
				ST_CHECK: state <= (tx == d_flg[FLG_FULL]) ? ST_MOVE : ST_IDLE;
				ST_MOVE: if (fin) state <= ST_WB;
				ST_WB: if (bus.mem_ack) begin
					idx <= (idx == 3'h3) ? 3'h0 : idx + 3'h1;
					if (idx == 3'h3) state <= ST_SAVE;
				end
				ST_SAVE: begin
					idx <= (idx == 3'h4) ? 3'h0 : idx + 3'h1;
					if (idx == 3'h4) begin
						state   <= ST_IDLE;
						last_ch <= ch;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// working copy of context and descriptor
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			init_ptr <= WORD_RST;
			tx       <= 1'b0;
			cur_ptr  <= WORD_RST;
			d_src    <= WORD_RST;
			d_len    <= '0;
			d_flg    <= WORD_RST;
		end else if (state == ST_CTX) begin
			if (idx == 3'(CTX_PTR)) init_ptr <= ctx_rd;
			if (idx == 3'(CTX_CTRL)) tx <= ctx_rd[CTRL_TX];
			if (idx == 3'(CTX_STAT)) cur_ptr <= ctx_rd;
		end else if (state == ST_FETCH && bus.mem_ack) begin
			unique case (idx[1:0])
				DW_SRC: d_src <= bus.mem_rdata;
				DW_LEN: d_len <= bus.mem_rdata[LEN_W-1:0];
				DW_DST: ;
				DW_FLG: d_flg <= bus.mem_rdata;
			endcase
		end
	end

	// transfer progress
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			addr  <= WORD_RST;
			rem   <= '0;
			moved <= '0;
			eop   <= 1'b0;
			err   <= 1'b0;
		end else if (state == ST_CHECK) begin
			addr  <= d_src;
			rem   <= d_len;
			moved <= '0;
			eop   <= 1'b0;
			err   <= 1'b0;
		end else if (state == ST_MOVE) begin
			if (bus.per_err) err <= 1'b1;
			if (bo_valid && bo_ready) moved <= moved + LEN_W'(pop4(bo_data[4:1]));
			if (tx && bi_valid) begin
				rem  <= rem - LEN_W'(nb);
				addr <= {addr[31:2] + 30'h1, 2'h0};
			end
			if (!tx && bi_valid) begin
				rem <= (rem > LEN_W'(pop4(bus.per_rx_be))) ? rem - LEN_W'(pop4(bus.per_rx_be)) : '0;
				if (bus.per_rx_eop) eop <= 1'b1;
			end
			if (!tx && bo_valid && bo_ready) addr <= addr + 32'h4;
		end
	end

	// ----------------------------------------
	// memory master
	// ----------------------------------------
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			bus.mem_req   <= 1'b0;
			bus.mem_we    <= 1'b0;
			bus.mem_addr  <= WORD_RST;
			bus.mem_wdata <= WORD_RST;
			bus.mem_be    <= 4'h0;
		end else if (bus.mem_req) begin
			if (bus.mem_ack) bus.mem_req <= 1'b0;
		end else if (state == ST_FETCH || state == ST_WB) begin
			bus.mem_req  <= 1'b1;
			bus.mem_we   <= (state == ST_WB);
			bus.mem_addr <= cur_ptr + {28'h0, idx[1:0], 2'h0};
			bus.mem_be   <= 4'hF;
			unique case (idx[1:0])
				DW_SRC: bus.mem_wdata <= d_src;
				DW_LEN: bus.mem_wdata <= {16'h0, d_len - moved};
				DW_DST: bus.mem_wdata <= WORD_RST;
				DW_FLG: bus.mem_wdata <= new_flg;
			endcase
		end else if (state == ST_MOVE && !err) begin
			if (tx && rem != '0 && bi_ready && !bo_valid) begin
				bus.mem_req  <= 1'b1;
				bus.mem_we   <= 1'b0;
				bus.mem_addr <= {addr[31:2], 2'h0};
				bus.mem_be   <= be_cur;
			end else if (!tx && bo_valid) begin
				bus.mem_req   <= 1'b1;
				bus.mem_we    <= 1'b1;
				bus.mem_addr  <= addr;
				bus.mem_wdata <= bo_data[36:5];
				bus.mem_be    <= bo_data[4:1];
			end
		end
	end

	// retire report and descriptor interrupt
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			RETIRE_O    <= 1'b0;
			RETIRE_CH_O <= '0;
			DESC_IRQ_O  <= 1'b0;
		end else begin
			RETIRE_O    <= (state == ST_SAVE) && (idx == 3'h4);
			RETIRE_CH_O <= ch;
			DESC_IRQ_O  <= (state == ST_SAVE) && (idx == 3'h4) && d_flg[FLG_IRQ] && !err;
		end
	end
endmodule

// ===== shared/fbd_pkg.sv
package fbd_pkg;
	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NUM_CH    = 16;
	localparam int CH_W      = 4;
	localparam int CTX_DEPTH = 128;
	localparam int CTX_AW    = 7;
	localparam int LEN_W     = 16;
	localparam int BUF_DEPTH = 2;
	localparam int BUF_W     = 37;

	// ----------------------------------------
	// context entry word offsets
	// ----------------------------------------
	localparam logic [2:0] CTX_PTR  = 3'h0;
	localparam logic [2:0] CTX_CTRL = 3'h1;
	localparam logic [2:0] CTX_STAT = 3'h2;
	localparam logic [2:0] CTX_SRC  = 3'h4;
	localparam logic [2:0] CTX_LEN  = 3'h5;
	localparam logic [2:0] CTX_DST  = 3'h6;
	localparam logic [2:0] CTX_FLG  = 3'h7;

	// ----------------------------------------
	// descriptor layout
	// ----------------------------------------
	localparam logic [1:0]  DW_SRC      = 2'h0;
	localparam logic [1:0]  DW_LEN      = 2'h1;
	localparam logic [1:0]  DW_DST      = 2'h2;
	localparam logic [1:0]  DW_FLG      = 2'h3;
	localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
	localparam int          FLG_WRAP    = 31;
	localparam int          FLG_IRQ     = 30;
	localparam int          FLG_LAST    = 29;
	localparam int          FLG_FULL    = 28;
	localparam int          CTRL_TX     = 0;
	localparam logic [31:0] WORD_RST    = 32'h0000_0000;
endpackage

// ===== shared/fbd_if.sv
interface fbd_if (input wire logic clk);
	logic        mem_req;
	logic        mem_we;
	logic [31:0] mem_addr;
	logic [31:0] mem_wdata;
	logic [3:0]  mem_be;
	logic        mem_ack;
	logic [31:0] mem_rdata;
	logic [15:0] per_req;
	logic [3:0]  per_ch;
	logic        per_act;
	logic        per_tx_valid;
	logic        per_tx_ready;
	logic [31:0] per_tx_data;
	logic [3:0]  per_tx_be;
	logic        per_tx_last;
	logic        per_rx_valid;
	logic        per_rx_ready;
	logic [31:0] per_rx_data;
	logic [3:0]  per_rx_be;
	logic        per_rx_eop;
	logic        per_err;
	logic [15:0] per_stat;

	modport dma (
		input  clk, mem_ack, mem_rdata, per_req, per_tx_ready, per_rx_valid,
		input  per_rx_data, per_rx_be, per_rx_eop, per_err, per_stat,
		output mem_req, mem_we, mem_addr, mem_wdata, mem_be, per_ch, per_act,
		output per_tx_valid, per_tx_data, per_tx_be, per_tx_last, per_rx_ready
	);
	modport far (
		output mem_ack, mem_rdata, per_req, per_tx_ready, per_rx_valid,
		output per_rx_data, per_rx_be, per_rx_eop, per_err, per_stat,
		input  clk, mem_req, mem_we, mem_addr, mem_wdata, mem_be, per_ch, per_act,
		input  per_tx_valid, per_tx_data, per_tx_be, per_tx_last, per_rx_ready
	);
endinterface

// ===== rtl/fbd_far.sv
// ----------------------------------------
// memory and peripheral end
// ----------------------------------------
module fbd_far (
	input  wire logic        MCLK_I,
	input  wire logic        RST_I,
	fbd_if.far               bus,
	output logic             U_MEM_REQ_O,
	output logic             U_MEM_WE_O,
	output logic [31:0]      U_MEM_ADDR_O,
	output logic [31:0]      U_MEM_WDATA_O,
	output logic [3:0]       U_MEM_BE_O,
	input  wire logic        U_MEM_ACK_I,
	input  wire logic [31:0] U_MEM_RDATA_I,
	input  wire logic [15:0] U_REQ_I,
	output logic [3:0]       U_CH_O,
	output logic             U_ACT_O,
	output logic             U_TX_VALID_O,
	input  wire logic        U_TX_READY_I,
	output logic [31:0]      U_TX_DATA_O,
	output logic [3:0]       U_TX_BE_O,
	output logic             U_TX_LAST_O,
	input  wire logic        U_RX_VALID_I,
	output logic             U_RX_READY_O,
	input  wire logic [31:0] U_RX_DATA_I,
	input  wire logic [3:0]  U_RX_BE_I,
	input  wire logic        U_RX_EOP_I,
	input  wire logic        U_ERR_I,
	input  wire logic [15:0] U_STAT_I
);
	import fbd_pkg::*;

	logic busy;

	// one memory access at a time, answered with registered data
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			busy          <= 1'b0;
			U_MEM_REQ_O   <= 1'b0;
			U_MEM_WE_O    <= 1'b0;
			U_MEM_ADDR_O  <= WORD_RST;
			U_MEM_WDATA_O <= WORD_RST;
			U_MEM_BE_O    <= 4'h0;
			bus.mem_ack   <= 1'b0;
			bus.mem_rdata <= WORD_RST;
		end else begin
			bus.mem_ack <= 1'b0;
			if (!busy && bus.mem_req && !bus.mem_ack) begin
				busy          <= 1'b1;
				U_MEM_REQ_O   <= 1'b1;
				U_MEM_WE_O    <= bus.mem_we;
				U_MEM_ADDR_O  <= bus.mem_addr;
				U_MEM_WDATA_O <= bus.mem_wdata;
				U_MEM_BE_O    <= bus.mem_be;
			end else if (busy && U_MEM_ACK_I) begin
				busy          <= 1'b0;
				U_MEM_REQ_O   <= 1'b0;
				bus.mem_ack   <= 1'b1;
				bus.mem_rdata <= U_MEM_RDATA_I;
			end
		end
	end

	// peripheral request, status and stream handshakes
	assign bus.per_req      = U_REQ_I;
	assign bus.per_err      = U_ERR_I;
	assign bus.per_stat     = U_STAT_I;
	assign U_CH_O           = bus.per_ch;
	assign U_ACT_O          = bus.per_act;
	assign U_TX_VALID_O     = bus.per_tx_valid;
	assign bus.per_tx_ready = U_TX_READY_I;
	assign U_TX_DATA_O      = bus.per_tx_data;
	assign U_TX_BE_O        = bus.per_tx_be;
	assign U_TX_LAST_O      = bus.per_tx_last;
	assign bus.per_rx_valid = U_RX_VALID_I;
	assign U_RX_READY_O     = bus.per_rx_ready;
	assign bus.per_rx_data  = U_RX_DATA_I;
	assign bus.per_rx_be    = U_RX_BE_I;
	assign bus.per_rx_eop   = U_RX_EOP_I;
endmodule

// ===== verif/fbd_props.sv
module fbd_props (
	input wire logic        clk,
	input wire logic        RST_I,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic        mem_ack,
	input wire logic [15:0] per_req,
	input wire logic [3:0]  per_ch,
	input wire logic        per_act,
	input wire logic        per_tx_valid,
	input wire logic        per_tx_ready,
	input wire logic [31:0] per_tx_data,
	input wire logic [3:0]  per_tx_be,
	input wire logic        per_tx_last,
	input wire logic        per_rx_valid,
	input wire logic        per_rx_ready,
	input wire logic        per_rx_eop
);
	default clocking @(posedge clk); endclocking
	default disable iff (RST_I);
	// ----------------------------------------
	// memory master
	// ----------------------------------------
	sequence acc_end;
		mem_ack ##1 !mem_req;
	endsequence
	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable({mem_we, mem_addr, mem_wdata}))
		else $error("request changed before ack");
	req_drop_a: assert property (mem_ack |-> acc_end)
		else $error("request held after ack");
	ack_pulse_a: assert property (mem_ack |=> !mem_ack)
		else $error("ack longer than one cycle");
	ack_owner_a: assert property (mem_ack |-> mem_req)
		else $error("ack without request");
	ack_delay_a: assert property ($rose(mem_req) |-> !mem_ack [*2])
		else $error("ack too early");
	word_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
		else $error("unaligned memory address");
	// ----------------------------------------
	// peripheral streams
	// ----------------------------------------
	sequence rx_close;
		per_rx_valid && per_rx_ready && per_rx_eop;
	endsequence
	tx_hold_a: assert property (per_tx_valid && !per_tx_ready |=>
		per_tx_valid && $stable({per_tx_data, per_tx_be, per_tx_last}))
		else $error("tx word changed while stalled");
	tx_bytes_a: assert property (per_tx_valid |-> per_tx_be != 4'h0)
		else $error("tx word without bytes");
	rx_close_a: assert property (rx_close |=> !per_rx_ready)
		else $error("rx taken after end of packet");
	chan_steady_a: assert property (per_act && $past(per_act) |-> $stable(per_ch))
		else $error("channel changed during movement");
	serve_req_a: assert property ($rose(per_act) |-> per_req[per_ch])
		else $error("service without request");
endmodule

// ===== verif/fbd_dma_tb.sv
module fbd_dma_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fbd_pkg::*;
	typedef struct packed {logic [31:0] a; logic [31:0] d; logic [31:0] m;} fbd_wr_t;
	logic        clk, rst, err, cfg_we, cfg_tx, cfg_rdy, retire, desc_irq, busy, mreq, mwe, mack, uact;
	logic        txv, txr, txl, rxv, rxr, rxeop;
	logic [3:0]  cfg_ch, retire_ch, mbe, uch, txbe, rxbe;
	logic [15:0] ch_en, u_req, stat;
	logic [31:0] cfg_ptr, maddr, mwd, mrd, txd, rxd, rw;
	logic [31:0] mem [0:511];
	fbd_wr_t     wq[$];
	logic [36:0] tq[$];
	logic [4:0]  rq[$];
	fbd_wr_t     w;
	int          fails, num_checks, seed, k, j;

	fbd_if bus (.clk(clk));
	fbd_dma u_fbd_dma (.MCLK_I(clk), .RST_I(rst), .CH_EN_I(ch_en), .CFG_WE_I(cfg_we), .CFG_CH_I(cfg_ch),
		.CFG_PTR_I(cfg_ptr), .CFG_TX_I(cfg_tx), .CFG_RDY_O(cfg_rdy), .RETIRE_O(retire),
		.RETIRE_CH_O(retire_ch), .DESC_IRQ_O(desc_irq), .BUSY_O(busy), .bus(bus));
	fbd_far u_fbd_far (.MCLK_I(clk), .RST_I(rst), .bus(bus), .U_MEM_REQ_O(mreq), .U_MEM_WE_O(mwe),
		.U_MEM_ADDR_O(maddr), .U_MEM_WDATA_O(mwd), .U_MEM_BE_O(mbe), .U_MEM_ACK_I(mack),
		.U_MEM_RDATA_I(mrd), .U_REQ_I(u_req), .U_CH_O(uch), .U_ACT_O(uact), .U_TX_VALID_O(txv),
		.U_TX_READY_I(txr), .U_TX_DATA_O(txd), .U_TX_BE_O(txbe), .U_TX_LAST_O(txl), .U_RX_VALID_I(rxv),
		.U_RX_READY_O(rxr), .U_RX_DATA_I(rxd), .U_RX_BE_I(rxbe), .U_RX_EOP_I(rxeop), .U_ERR_I(err),
		.U_STAT_I(stat));
	fbd_props u_fbd_props (.clk(clk), .RST_I(rst), .mem_req(bus.mem_req), .mem_we(bus.mem_we),
		.mem_addr(bus.mem_addr), .mem_wdata(bus.mem_wdata), .mem_ack(bus.mem_ack), .per_req(bus.per_req),
		.per_ch(bus.per_ch), .per_act(bus.per_act), .per_tx_valid(bus.per_tx_valid),
		.per_tx_ready(bus.per_tx_ready), .per_tx_data(bus.per_tx_data), .per_tx_be(bus.per_tx_be),
		.per_tx_last(bus.per_tx_last), .per_rx_valid(bus.per_rx_valid), .per_rx_ready(bus.per_rx_ready),
		.per_rx_eop(bus.per_rx_eop));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] bm(input logic [3:0] b);
		return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
	endfunction
	task automatic check(input string n, input logic [39:0] s, input logic [39:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic close_out;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// descriptor image: src, length, junk destination, flags on top nibble
	task automatic desc(input logic [31:0] d, input logic [31:0] s, input logic [15:0] len, input logic [3:0] f);
		mem[d[10:2]] = s;
		mem[d[10:2]+9'h1] = {16'h0, len};
		mem[d[10:2]+9'h2] = 32'hDEAD_BEEF;
		mem[d[10:2]+9'h3] = {f, 28'h0};
	endtask
	// expected write-back of one retired descriptor
	task automatic wb(input logic [31:0] d, input logic [15:0] len, input logic [3:0] f, input logic [31:0] fm);
		wq.push_back('{d, 32'h0, 32'h0});
		wq.push_back('{d + 32'h4, {16'h0, len}, 32'h0000_FFFF});
		wq.push_back('{d + 32'h8, 32'h0, 32'hFFFF_FFFF});
		wq.push_back('{d + 32'hC, {f, 12'h0, stat}, fm});
	endtask
	// wait for all notes to be used, then release the request and wait for idle
	task automatic drain;
		for (k = 0; k < 3000 && (wq.size() || tq.size() || rq.size()); k++) @(posedge clk);
		#1 u_req = 16'h0;
		for (j = 0; j < 100 && busy; j++) begin
			@(posedge clk);
			#1;
		end
		if (k == 3000 || j == 100) begin
			fails++;
			close_out();
		end
	endtask
	// config write, held one more cycle with pointer 0x700 while not ready to see it refused
	task automatic cfg(input logic [3:0] c, input logic [31:0] p, input logic t);
		for (k = 0; k < 20 && !cfg_rdy; k++) begin
			@(posedge clk);
			#1;
		end
		if (k == 20) begin
			fails++;
			close_out();
		end
		cfg_we = 1;
		cfg_ch = c;
		cfg_ptr = p;
		cfg_tx = t;
		@(posedge clk);
		#1 cfg_ptr = 32'h0000_0700;
		@(posedge clk);
		#1 cfg_we = 0;
	endtask

	// ----------------------------------------
	// clock, memory and monitors
	// ----------------------------------------
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	// user memory: random latency, one ack per request, byte-enabled writes
	initial begin
		int n;
		mack = 0;
		mrd = 32'h0;
		forever begin
			@(posedge clk);
			if (mreq) begin
				repeat (1'($random(seed))) @(posedge clk);
				#1 mack = 1;
				mrd = mem[maddr[10:2]];
				if (mwe) begin
					for (int b = 0; b < 4; b++) if (mbe[b]) mem[maddr[10:2]][8*b+:8] = mwd[8*b+:8];
					w = wq.size() ? wq.pop_front() : fbd_wr_t'{32'hFFFF_FFFF, 32'h0, 32'h0};
					check("wr_addr", maddr, w.a);
					check("wr_data", mwd & w.m, w.d & w.m);
				end
				@(posedge clk);
				#1 mack = 0;
				for (n = 0; n < 8 && mreq; n++) @(posedge clk);
			end
		end
	end
	// peripheral stalls at random
	always @(posedge clk) #1 txr = 1'($random(seed));
	always @(posedge clk) if (txv && txr) check("tx_word", {txd & bm(txbe), txbe, txl}, tq.pop_front());
	// every tx word in this bench belongs to channel 3 while moving
	always @(posedge clk) if (txv && txr) check("tx_chan", {uact, uch}, 5'h13);
	always @(posedge clk) if (retire) check("retire", {retire_ch, desc_irq}, rq.pop_front());

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 66028;
		{fails, num_checks} = 0;
		{cfg_we, cfg_tx, txr, rxv, rxeop, err} = 0;
		{cfg_ch, rxbe, ch_en, u_req, stat, cfg_ptr, rxd} = 0;
		for (k = 0; k < 512; k++) mem[k] = $random(seed);
		rst = 1;
		repeat (5) @(posedge clk);
		#1 rst = 0;
		// requests on disabled channels are ignored
		u_req = 16'hFFFF;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			check("busy", busy, 0);
		end
		#1 u_req = 16'h0;
		cfg(4'h3, 32'h0000_0100, 1'b1);
		cfg(4'h9, 32'h0000_0200, 1'b0);
		// tx ring: unaligned start, then wrapping descriptor
		stat = 16'($random(seed));
		desc(32'h100, 32'h301, 16'd7, 4'h7);
		desc(32'h110, 32'h340, 16'd4, 4'hB);
		tq.push_back({mem[9'hC0] & bm(4'hE), 4'hE, 1'b0});
		tq.push_back({mem[9'hC1], 4'hF, 1'b1});
		tq.push_back({mem[9'hD0], 4'hF, 1'b1});
		wb(32'h100, 16'd0, 4'h0, 32'h1000_FFFF);
		wb(32'h110, 16'd0, 4'h0, 32'h1000_FFFF);
		rq.push_back({4'h3, 1'b1});
		rq.push_back({4'h3, 1'b0});
		ch_en = 16'h0208;
		u_req = 16'h0008;
		drain();
		// wrap returned to the first slot; refill it and expect a reuse there
		desc(32'h100, 32'h380, 16'd4, 4'h3);
		tq.push_back({mem[9'hE0], 4'hF, 1'b1});
		wb(32'h100, 16'd0, 4'h0, 32'h1000_FFFF);
		rq.push_back({4'h3, 1'b0});
		u_req = 16'h0008;
		drain();
		// tx error: one word leaves, residue kept, no interrupt, wrap back
		desc(32'h110, 32'h3C0, 16'd8, 4'hD);
		tq.push_back({mem[9'hF0], 4'hF, 1'b0});
		wb(32'h110, 16'd4, 4'h0, 32'h1000_FFFF);
		rq.push_back({4'h3, 1'b0});
		{err, u_req} = {1'b1, 16'h0008};
		drain();
		err = 0;
		// rx: end of packet closes a longer buffer early
		stat = 16'($random(seed));
		rw = $random(seed);
		desc(32'h200, 32'h400, 16'd8, 4'hC);
		wq.push_back('{32'h400, rw, 32'hFFFF_FFFF});
		wb(32'h200, 16'd4, 4'h3, 32'h3000_FFFF);
		rq.push_back({4'h9, 1'b1});
		u_req = 16'h0200;
		{rxv, rxeop, rxbe, rxd} = {1'b1, 1'b1, 4'hF, rw};
		for (k = 0; k < 300; k++) begin
			@(posedge clk);
			if (rxr) break;
		end
		#1 {rxv, rxeop} = 2'b00;
		if (k == 300) begin
			fails++;
			close_out();
		end
		drain();
		close_out();
	end
endmodule
